// >>> cpu_register_set.sv
// processor register set and datapath, reached over apb
`timescale 1ns/100ps

// Notes on behaviour
// RULE_01: sixteen 32-bit general registers, three control and four system registers.
// RULE_02: register zero is the index in indexed and global-base indexed loads.
// RULE_03: register fifteen is stack pointer; trap and return move status and pc.
// RULE_04: global base gives indexed base; vector base gives trap vector area.
// RULE_05: mac pair holds products, return register holds link, pc holds address.
// RULE_06: after reset stack pointer and pc load from reset vector entries.
// RULE_07: reset sets status mask bits to ones, reserved zero, vector base zero.
// RULE_08: byte and word loads are sign-extended to 32 bits.
// RULE_09: misaligned word or longword access raises address error; bytes anywhere.
// RULE_10: move, add, compare-equal 8-bit immediates are sign-extended.
// RULE_11: test and logic immediates are zero-extended; and clears upper 24 bits.
// RULE_12: long immediates come from a pc-relative table load, not the code.
// RULE_13: every instruction is exactly 16 bits.
// RULE_14: basic instructions complete one per clock.
// RULE_15: arithmetic is register to register; bit logic works on memory bytes.
// RULE_16: unconditional branches run the following instruction before jumping.
// RULE_17: conditional branches exist with and without a delay slot.
// RULE_18: 16x16 multiply to 32 bits takes one to two cycles.
// RULE_19: 16x16 multiply plus 64-bit accumulate takes two to three cycles.
// RULE_20: 32x32 multiply and accumulate to 64 bits take two to four cycles.
// RULE_21: condition flag set only by compares and tests, tested by branches.
module cpu_register_set
	import cpu_regs_pkg::*;
(
	input  wire logic        pclk,          // 250 MHz bus clock
	input  wire logic        presetn,       // async reset, active low
	input  wire logic        psel,          // apb select
	input  wire logic        penable,       // apb access phase
	input  wire logic        pwrite,        // apb direction
	input  wire logic [7:0]  paddr,         // apb byte address
	input  wire logic [31:0] pwdata,        // apb write data
	input  wire logic [31:0] reset_sp_vec,  // stack pointer vector entry
	input  wire logic [31:0] reset_pc_vec,  // program counter vector entry
	output logic      [31:0] prdata,        // apb read data
	output logic             pready,        // apb ready
	output logic             pslverr,       // apb error, unmapped address
	output logic             core_busy      // boot or multiply in progress
);

	// ------------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------------
	function automatic logic [31:0] sext8(input logic [7:0] v);
		sext8 = {{24{v[7]}}, v};
	endfunction : sext8

	function automatic logic [31:0] sext16(input logic [15:0] v);
		sext16 = {{16{v[15]}}, v};
	endfunction : sext16

	// big-endian byte lane of an aligned longword
	function automatic logic [7:0] lane8(input logic [31:0] w, input logic [1:0] a);
		case (a)
			2'h0:    lane8 = w[31:24];
			2'h1:    lane8 = w[23:16];
			2'h2:    lane8 = w[15:8];
			default: lane8 = w[7:0];
		endcase
	endfunction : lane8

	// ------------------------------------------------------------------
	// state
	// ------------------------------------------------------------------
	logic [31:0] gpr_q [16];
	logic [31:0] gpr_d [16];
	logic [31:0] stack_q [16];
	logic [31:0] sr_q, sr_d, gbr_q, gbr_d, vbr_q, vbr_d;
	logic [31:0] multiply_acc_high_q, multiply_acc_high_d, multiply_acc_low_q, multiply_acc_low_d, pr_q, pr_d, pc_q, pc_d;
	logic [15:0] insn_q, insn_d;
	logic [31:0] mdata_q, mdata_d, eaddr_q, eaddr_d, mout_q, mout_d;
	logic        slot_q, slot_d, aerr_q, aerr_d, ill_q, ill_d;
	logic [31:0] slot_tgt_q, slot_tgt_d;
	logic [63:0] pend_q, pend_d;
	logic        pend_hi_q, pend_hi_d;
	logic [2:0]  cnt_q, cnt_d;
	core_state_t state_q, state_d;
	logic [31:0] prdata_q, prdata_d;
	logic        pready_q, pready_d, pslverr_q, pslverr_d, busy_q, busy_d;
	logic        push_we;
	logic [3:0]  push_idx;
	logic [31:0] push_sr, push_pc;

	assign prdata    = prdata_q;
	assign pready    = pready_q;
	assign pslverr   = pslverr_q;
	assign core_busy = busy_q;

	// ------------------------------------------------------------------
	// next-state logic
	// ------------------------------------------------------------------
	always_comb begin
		logic        acc_done, wr_done, mapped, exec, taken;
		logic [3:0]  rn, rm, sub;
		logic [31:0] rn_v, rm_v, r0_v, ea, ld, nxt_pc, tgt, imm_s, imm_z, sp;
		logic [1:0]  sz;
		logic        mis;
		logic [7:0]  mb;
		logic [63:0] prod;
		op_t         op;
		acc_done = psel && penable && pready_q;
		wr_done  = acc_done && pwrite;
		mapped   = (paddr[1:0] == 2'h0) && (paddr <= OFF_CORE_ST) &&
		           (paddr != 8'h5C);
		exec     = wr_done && (paddr == OFF_INSN);
		rn       = pwdata[11:8];
		rm       = pwdata[7:4];
		sub      = pwdata[3:0];
		op       = op_t'(pwdata[15:12]);
		rn_v     = gpr_q[rn];
		rm_v     = gpr_q[rm];
		r0_v     = gpr_q[GPR_IDX];
		sp       = gpr_q[GPR_SP];
		imm_s    = sext8(pwdata[7:0]);                       // RULE_10
		imm_z    = {24'h000000, pwdata[7:0]};               // RULE_11
		ea       = WORD_RESET;
		ld       = WORD_RESET;
		sz       = 2'h2;
		mis      = 1'b0;
		mb       = 8'h00;
		prod     = 64'h0;
		taken    = 1'b0;
		tgt      = pc_q + 32'h4 + {pwdata[10:0], 1'b0} + {{20{pwdata[11]}}, 12'h000};
		nxt_pc   = pc_q + 32'h2;                             // RULE_13
		gpr_d    = gpr_q;
		sr_d     = sr_q;
		gbr_d    = gbr_q;
		vbr_d    = vbr_q;
		multiply_acc_high_d   = multiply_acc_high_q;
		multiply_acc_low_d   = multiply_acc_low_q;
		pr_d     = pr_q;
		pc_d     = pc_q;
		insn_d   = insn_q;
		mdata_d  = mdata_q;
		eaddr_d  = eaddr_q;
		mout_d   = mout_q;
		slot_d   = slot_q;
		slot_tgt_d = slot_tgt_q;
		aerr_d   = aerr_q;
		ill_d    = ill_q;
		pend_d   = pend_q;
		pend_hi_d = pend_hi_q;
		cnt_d    = cnt_q;
		state_d  = state_q;
		prdata_d = prdata_q;
		pready_d = 1'b0;
		pslverr_d = 1'b0;
		push_we  = 1'b0;
		push_idx = sp[5:2];
		push_sr  = sr_q;
		push_pc  = pc_q;

		// --------------------------------------------------------------
		// boot and multiply sequencing
		// --------------------------------------------------------------
		case (state_q)
			ST_BOOT: begin
				gpr_d[GPR_SP] = reset_sp_vec;                   // RULE_06
				pc_d          = reset_pc_vec;                   // RULE_06
				state_d       = ST_RUN;
			end
			ST_MUL: begin
				cnt_d = cnt_q - 3'h1;
				if (cnt_q == 3'h1) begin
					multiply_acc_low_d = pend_q[31:0];                        // RULE_05
					if (pend_hi_q) begin
						multiply_acc_high_d = pend_q[63:32];
					end
					state_d = ST_RUN;
				end
			end
			default: begin
			end
		endcase

		// --------------------------------------------------------------
		// apb slave: answers one cycle into the access phase, stalls when busy
		// --------------------------------------------------------------
		if (psel && penable && !pready_q && state_q == ST_RUN) begin
			pready_d  = 1'b1;
			pslverr_d = !mapped;
			case (paddr)
				OFF_STATUS:   prdata_d = sr_q;
				OFF_GBASE:    prdata_d = gbr_q;
				OFF_VBASE:    prdata_d = vbr_q;
				OFF_MULTIPLY_ACC_HIGH:     prdata_d = multiply_acc_high_q;
				OFF_MULTIPLY_ACC_LOW:     prdata_d = multiply_acc_low_q;
				OFF_RETADDR:  prdata_d = pr_q;
				OFF_PCNT:     prdata_d = pc_q;
				OFF_INSN:     prdata_d = {16'h0000, insn_q};
				OFF_MEM_DATA: prdata_d = mdata_q;
				OFF_EFF_ADDR: prdata_d = eaddr_q;
				OFF_MEM_OUT:  prdata_d = mout_q;
				OFF_CORE_ST:  prdata_d = {28'h0000000, ill_q, aerr_q, slot_q,
				                          state_q != ST_RUN};
				default:      prdata_d = (mapped && paddr < OFF_STATUS) ? gpr_q[paddr[5:2]] :
				                         WORD_RESET;
			endcase
		end

		if (wr_done && mapped) begin
			case (paddr)
				OFF_STATUS:   sr_d     = pwdata & SR_WRITE_MASK;  // RULE_07
				OFF_GBASE:    gbr_d    = pwdata;
				OFF_VBASE:    vbr_d    = pwdata;
				OFF_MULTIPLY_ACC_HIGH:     multiply_acc_high_d   = pwdata;
				OFF_MULTIPLY_ACC_LOW:     multiply_acc_low_d   = pwdata;
				OFF_RETADDR:  pr_d     = pwdata;
				OFF_PCNT:     pc_d     = {pwdata[31:1], 1'b0};
				OFF_MEM_DATA: mdata_d  = pwdata;
				OFF_CORE_ST: begin
					// write one to clear; an error raised by this same write survives
					if (pwdata[CST_ADDR_ERR]) aerr_d = 1'b0;
					if (pwdata[CST_ILLEGAL])  ill_d  = 1'b0;
				end
				default: begin
					if (paddr < OFF_STATUS) gpr_d[paddr[5:2]] = pwdata;  // RULE_01
				end
			endcase
		end

		// --------------------------------------------------------------
		// instruction execute, one per issuing write
		// --------------------------------------------------------------
		if (exec) begin
			insn_d = pwdata[15:0];
			case (op)
				OP_NOP: begin
				end
				OP_MOVI: gpr_d[rn] = imm_s;                         // RULE_10
				OP_ADDI: gpr_d[rn] = rn_v + imm_s;                  // RULE_10
				OP_CMPEQI: sr_d[SR_T_BIT] = (r0_v == imm_s);        // RULE_21
				OP_LOGI: begin
					case (pwdata[9:8])
						2'h0:    sr_d[SR_T_BIT] = ((r0_v & imm_z) == WORD_RESET); // RULE_21
						2'h1:    gpr_d[GPR_IDX] = r0_v & imm_z;  // RULE_11
						2'h2:    gpr_d[GPR_IDX] = r0_v | imm_z;  // RULE_11
						default: gpr_d[GPR_IDX] = r0_v ^ imm_z;  // RULE_11
					endcase
				end
				OP_ALU: begin                                       // RULE_15
					case (sub)
						4'h0:    gpr_d[rn] = rm_v;
						4'h1:    gpr_d[rn] = rn_v + rm_v;
						4'h2:    gpr_d[rn] = rn_v - rm_v;
						4'h3:    sr_d[SR_T_BIT] = (rn_v == rm_v);           // RULE_21
						4'h4:    sr_d[SR_T_BIT] = ($signed(rn_v) >= $signed(rm_v)); // RULE_21
						default: ill_d = 1'b1;
					endcase
				end
				OP_LOAD, OP_LDPC: begin
					if (op == OP_LDPC) begin
						ea = (pc_q & 32'hFFFFFFFC) + 32'h4 + {22'h0, pwdata[7:0], 2'h0}; // RULE_12
					end else begin
						sz = sub[1:0];
						case (sub[3:2])
							2'h0:    ea = rm_v;
							2'h1:    ea = r0_v + rm_v;             // RULE_02
							default: ea = r0_v + gbr_q;            // RULE_02 RULE_04
						endcase
					end
					case (sz)
						2'h0:    ld = sext8(lane8(mdata_q, ea[1:0]));       // RULE_08
						2'h1:    ld = sext16(ea[1] ? mdata_q[15:0] : mdata_q[31:16]); // RULE_08
						default: ld = mdata_q;
					endcase
					mis = (sz == 2'h1 && ea[0]) || (sz != 2'h0 && sz != 2'h1 &&
					      ea[1:0] != 2'h0);                          // RULE_09
					eaddr_d = ea;
					// misaligned data is not guaranteed, so the target is left alone
					if (mis) aerr_d = 1'b1;                           // RULE_09
					else gpr_d[rn] = ld;                              // RULE_15
				end
				OP_MUL: begin
					state_d   = ST_MUL;
					pend_hi_d = 1'b1;
					case (sub)
						4'h0: begin
							prod      = {32'h0, {16'h0, rn_v[15:0]} * {16'h0, rm_v[15:0]}};
							pend_hi_d = 1'b0;
							cnt_d     = LAT_MUL16;                       // RULE_18
						end
						4'h1: begin
							prod      = {32'h0, sext16(rn_v[15:0]) * sext16(rm_v[15:0])};
							pend_hi_d = 1'b0;
							cnt_d     = LAT_MUL16;                       // RULE_18
						end
						4'h2: begin
							prod  = {multiply_acc_high_q, multiply_acc_low_q} +
							        {{32{1'b0}}, 32'h0} +
							        64'($signed(sext16(rn_v[15:0])) *
							            $signed(sext16(rm_v[15:0])));
							cnt_d = LAT_MAC16;                           // RULE_19
						end
						4'h3: begin
							prod  = {32'h0, rn_v} * {32'h0, rm_v};
							cnt_d = LAT_MUL32;                           // RULE_20
						end
						4'h4: begin
							prod  = 64'($signed({{32{rn_v[31]}}, rn_v}) *
							            $signed({{32{rm_v[31]}}, rm_v}));
							cnt_d = LAT_MUL32;                           // RULE_20
						end
						4'h5: begin
							prod  = {multiply_acc_high_q, multiply_acc_low_q} +
							        64'($signed({{32{rn_v[31]}}, rn_v}) *
							            $signed({{32{rm_v[31]}}, rm_v}));
							cnt_d = LAT_MUL32;                           // RULE_20
						end
						default: begin
							state_d = ST_RUN;
							ill_d   = 1'b1;
						end
					endcase
					pend_d = prod;
				end
				OP_BRA, OP_JUMP: begin
					if (op == OP_JUMP) begin
						tgt = sub[0] ? pr_q : rn_v;
						if (!sub[0]) pr_d = pc_q + 32'h4;            // RULE_05
					end
					// a branch sitting in a delay slot is refused
					if (slot_q) ill_d = 1'b1;
					else begin
						slot_d     = 1'b1;                            // RULE_16
						slot_tgt_d = tgt;
					end
				end
				OP_BCOND: begin
					tgt   = pc_q + 32'h4 + {{23{pwdata[7]}}, pwdata[7:0], 1'b0};
					taken = (sr_q[SR_T_BIT] == pwdata[8]);            // RULE_21
					if (slot_q) ill_d = 1'b1;
					else if (taken && pwdata[9]) begin
						slot_d     = 1'b1;                            // RULE_17
						slot_tgt_d = tgt;
					end else if (taken) begin
						nxt_pc = tgt;                                  // RULE_17
					end
				end
				OP_TRAP: begin
					if (sp[1:0] != 2'h0) aerr_d = 1'b1;              // RULE_09
					push_we  = 1'b1;                                  // RULE_03
					push_idx = sp[5:2] - 4'h1;
					push_sr  = sr_q;
					push_pc  = nxt_pc;
					gpr_d[GPR_SP] = sp - 32'h8;                       // RULE_03
					nxt_pc = vbr_q + {22'h0, pwdata[7:0], 2'h0};     // RULE_04
				end
				OP_RTE: begin
					nxt_pc = stack_q[sp[5:2]];                        // RULE_03
					sr_d   = stack_q[sp[5:2] + 4'h1] & SR_WRITE_MASK;
					gpr_d[GPR_SP] = sp + 32'h8;
				end
				OP_BITMEM: begin                                      // RULE_15
					ea = r0_v + gbr_q;
					mb = lane8(mdata_q, ea[1:0]);
					eaddr_d = ea;
					case (pwdata[9:8])
						2'h0:    sr_d[SR_T_BIT] = ((mb & pwdata[7:0]) == 8'h00); // RULE_21
						2'h1:    mout_d = {24'h000000, mb & pwdata[7:0]};
						2'h2:    mout_d = {24'h000000, mb | pwdata[7:0]};
						default: mout_d = {24'h000000, mb ^ pwdata[7:0]};
					endcase
				end
				default: ill_d = 1'b1;
			endcase
			// the delay slot has run, so the saved target now takes over
			if (slot_q) begin
				nxt_pc = slot_tgt_q;                                  // RULE_16
				slot_d = 1'b0;
			end
			pc_d = nxt_pc;                                          // RULE_14
		end
		busy_d = (state_d != ST_RUN);
	end

	// ------------------------------------------------------------------
	// registers
	// ------------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (int i = 0; i < 16; i++) gpr_q[i] <= WORD_RESET;
			sr_q       <= SR_RESET;                                   // RULE_07
			vbr_q      <= VBASE_RESET;                                // RULE_07
			gbr_q      <= WORD_RESET;
			multiply_acc_high_q     <= WORD_RESET;
			multiply_acc_low_q     <= WORD_RESET;
			pr_q       <= WORD_RESET;
			pc_q       <= WORD_RESET;
			insn_q     <= 16'h0000;
			mdata_q    <= WORD_RESET;
			eaddr_q    <= WORD_RESET;
			mout_q     <= WORD_RESET;
			slot_q     <= 1'b0;
			slot_tgt_q <= WORD_RESET;
			aerr_q     <= 1'b0;
			ill_q      <= 1'b0;
			pend_q     <= 64'h0;
			pend_hi_q  <= 1'b0;
			cnt_q      <= 3'h0;
			state_q    <= ST_BOOT;
			prdata_q   <= WORD_RESET;
			pready_q   <= 1'b0;
			pslverr_q  <= 1'b0;
			busy_q     <= 1'b1;
		end else begin
			gpr_q      <= gpr_d;
			sr_q       <= sr_d;
			vbr_q      <= vbr_d;
			gbr_q      <= gbr_d;
			multiply_acc_high_q     <= multiply_acc_high_d;
			multiply_acc_low_q     <= multiply_acc_low_d;
			pr_q       <= pr_d;
			pc_q       <= pc_d;
			insn_q     <= insn_d;
			mdata_q    <= mdata_d;
			eaddr_q    <= eaddr_d;
			mout_q     <= mout_d;
			slot_q     <= slot_d;
			slot_tgt_q <= slot_tgt_d;
			aerr_q     <= aerr_d;
			ill_q      <= ill_d;
			pend_q     <= pend_d;
			pend_hi_q  <= pend_hi_d;
			cnt_q      <= cnt_d;
			state_q    <= state_d;
			prdata_q   <= prdata_d;
			pready_q   <= pready_d;
			pslverr_q  <= pslverr_d;
			busy_q     <= busy_d;
		end
	end

	// stack words hold no control state, so they carry no reset
	always_ff @(posedge pclk) begin
		if (push_we) begin
			stack_q[push_idx]        <= push_sr;
			stack_q[push_idx - 4'h1] <= push_pc;
		end
	end

endmodule : cpu_register_set

// >>> cpu_regs_pkg.sv
// constants, register map and encodings for the processor register set block
package cpu_regs_pkg;

	// ------------------------------------------------------------------
	// register map (byte addresses, one 32-bit word each)
	// ------------------------------------------------------------------
	localparam logic [7:0] OFF_GPR_BASE = 8'h00;  // 16 words, 0x00..0x3C
	localparam logic [7:0] OFF_STATUS   = 8'h40;
	localparam logic [7:0] OFF_GBASE    = 8'h44;
	localparam logic [7:0] OFF_VBASE    = 8'h48;
	localparam logic [7:0] OFF_MULTIPLY_ACC_HIGH     = 8'h4C;
	localparam logic [7:0] OFF_MULTIPLY_ACC_LOW     = 8'h50;
	localparam logic [7:0] OFF_RETADDR  = 8'h54;
	localparam logic [7:0] OFF_PCNT     = 8'h58;
	localparam logic [7:0] OFF_INSN     = 8'h60;
	localparam logic [7:0] OFF_MEM_DATA = 8'h64;
	localparam logic [7:0] OFF_EFF_ADDR = 8'h68;
	localparam logic [7:0] OFF_MEM_OUT  = 8'h6C;
	localparam logic [7:0] OFF_CORE_ST  = 8'h70;

	// ------------------------------------------------------------------
	// status register fields and reset values
	// ------------------------------------------------------------------
	localparam int          SR_T_BIT      = 0;
	localparam int          SR_IMASK_LSB  = 4;
	localparam logic [31:0] SR_WRITE_MASK = 32'h000003F3;  // reserved bits stay zero
	localparam logic [31:0] SR_RESET      = 32'h000000F0;  // mask bits all ones
	localparam logic [31:0] VBASE_RESET   = 32'h00000000;
	localparam logic [31:0] WORD_RESET    = 32'h00000000;

	// core status fields
	localparam int CST_BUSY     = 0;
	localparam int CST_SLOT     = 1;
	localparam int CST_ADDR_ERR = 2;
	localparam int CST_ILLEGAL  = 3;

	// ------------------------------------------------------------------
	// multiply latencies in cycles
	// ------------------------------------------------------------------
	localparam logic [2:0] LAT_MUL16 = 3'h2;
	localparam logic [2:0] LAT_MAC16 = 3'h3;
	localparam logic [2:0] LAT_MUL32 = 3'h4;

	localparam int GPR_SP  = 15;
	localparam int GPR_IDX = 0;

	// ------------------------------------------------------------------
	// 16-bit instruction: op[15:12] rn[11:8] rm[7:4] sub[3:0] / imm[7:0]
	// ------------------------------------------------------------------
	typedef enum logic [3:0] {
		OP_NOP    = 4'b0000,
		OP_MOVI   = 4'b0001,
		OP_ADDI   = 4'b0010,
		OP_CMPEQI = 4'b0011,
		OP_LOGI   = 4'b0100,
		OP_ALU    = 4'b0101,
		OP_LOAD   = 4'b0110,
		OP_LDPC   = 4'b0111,
		OP_MUL    = 4'b1000,
		OP_BRA    = 4'b1001,
		OP_BCOND  = 4'b1010,
		OP_JUMP   = 4'b1011,
		OP_TRAP   = 4'b1100,
		OP_RTE    = 4'b1101,
		OP_BITMEM = 4'b1110,
		OP_BAD    = 4'b1111
	} op_t;

	typedef enum logic [1:0] {
		ST_BOOT = 2'b00,
		ST_RUN  = 2'b01,
		ST_MUL  = 2'b10
	} core_state_t;

endpackage : cpu_regs_pkg

// >>> cpu_register_set_checker.sv
// assertion checker for the processor register set ports
`timescale 1ns/100ps
module cpu_register_set_checker (
	input wire logic        pclk,          // clock
	input wire logic        presetn,       // reset, active low
	input wire logic        psel,          // select
	input wire logic        penable,       // access phase
	input wire logic        pwrite,        // direction
	input wire logic [7:0]  paddr,         // address
	input wire logic [31:0] pwdata,        // write data
	input wire logic [31:0] reset_sp_vec,  // sp vector
	input wire logic [31:0] reset_pc_vec,  // pc vector
	input wire logic [31:0] prdata,        // read data
	input wire logic        pready,        // ready
	input wire logic        pslverr,       // error
	input wire logic        core_busy      // busy
);
	// ------------------------------------------------------------------
	// bus and core timing
	// ------------------------------------------------------------------
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);

	property p_take; psel && penable && !pready && !core_busy |=> pready; endproperty
	a_take: assert property (p_take) else $error("idle access not answered");
	property p_pulse; pready |=> !pready; endproperty
	a_pulse: assert property (p_pulse) else $error("ready longer than a cycle");
	property p_err_rdy; pslverr |-> pready; endproperty
	a_err_rdy: assert property (p_err_rdy) else $error("error without ready");
	property p_refuse;
		pready && (paddr[1:0] != 2'h0 || paddr == 8'h5C || paddr > 8'h70) |-> pslverr;
	endproperty
	a_refuse: assert property (p_refuse) else $error("bad address accepted");
	property p_err_zero; pready && pslverr && !pwrite |-> prdata == 32'h00000000; endproperty
	a_err_zero: assert property (p_err_zero) else $error("refused read not zero");
	property p_boot; $rose(presetn) |=> !core_busy; endproperty
	a_boot: assert property (p_boot) else $error("boot load not done");
	property p_busy_wait; pready |-> !$past(core_busy); endproperty
	a_busy_wait: assert property (p_busy_wait) else $error("answer while busy");
	property p_mul_end; $rose(core_busy) |-> ##[1:4] !core_busy; endproperty
	a_mul_end: assert property (p_mul_end) else $error("multiply too long");
	property p_mul16;
		pready && pwrite && paddr == 8'h60 && pwdata[15:12] == 4'h8 && pwdata[3:1] == 3'h0
			|=> core_busy ##1 core_busy ##1 !core_busy;
	endproperty
	a_mul16: assert property (p_mul16) else $error("short multiply latency wrong");
	property p_mac16;
		pready && pwrite && paddr == 8'h60 && pwdata[15:12] == 4'h8 && pwdata[3:0] == 4'h2
			|=> core_busy[*3] ##1 !core_busy;
	endproperty
	a_mac16: assert property (p_mac16) else $error("short accumulate latency wrong");
endmodule : cpu_register_set_checker

bind cpu_register_set cpu_register_set_checker u_chk (
	.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
	.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .reset_sp_vec(reset_sp_vec),
	.reset_pc_vec(reset_pc_vec), .prdata(prdata), .pready(pready),
	.pslverr(pslverr), .core_busy(core_busy)
);

// >>> cpu_register_set_tb.sv
// self-checking bench for the processor register set
`timescale 1ns/100ps
module cpu_register_set_tb
	import cpu_regs_pkg::*;
;
	logic        pclk = 1'b0;
	logic        presetn = 1'b0;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] reset_sp_vec;
	logic [31:0] reset_pc_vec;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        core_busy;
	int          n_errors = 0;
	int          checks = 0;
	logic [15:0] lfsr = 16'h1825;
	logic [31:0] rd;
	logic        er;
	logic [31:0] pc_e;
	logic [31:0] t;
	logic [31:0] gpr [16];

	cpu_register_set u_cpu_register_set (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .reset_sp_vec(reset_sp_vec),
		.reset_pc_vec(reset_pc_vec), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .core_busy(core_busy)
	);

	always #2 pclk = ~pclk;

	// ------------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------------
	function automatic logic [31:0] rnd();
		lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
		return {lfsr, ~lfsr};
	endfunction : rnd

	task end_of_test;
		$display("checks %0d errors %0d", checks, n_errors);
		if (n_errors == 0 && checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : end_of_test

	task chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			n_errors++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk

	// one idle edge first, so psel is never driven twice in a time step
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int i;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		i = 0;
		do begin
			@(posedge pclk);
			i++;
		end while (pready !== 1'b1 && i < 40);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (i >= 40) begin
			n_errors++;
			end_of_test();
		end
	endtask : apb

	task rchk(input logic [7:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		chk(rd, exp);
	endtask : rchk

	task ex(input logic [15:0] c);
		apb(1'b1, OFF_INSN, {16'h0000, c});
		pc_e += 32'h2;
	endtask : ex

	// ------------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------------
	initial begin
		reset_sp_vec = rnd() & 32'hFFFFFFFC;
		reset_pc_vec = rnd() & 32'hFFFFFFFE;
		pc_e = reset_pc_vec;
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		rchk(OFF_STATUS, 32'hF << SR_IMASK_LSB);
		rchk(OFF_VBASE, 32'h0);
		rchk(8'h3C, reset_sp_vec);
		rchk(OFF_PCNT, reset_pc_vec);
		$display("test reset done");
		for (int k = 0; k < 16; k++) begin
			gpr[k] = rnd();
			apb(1'b1, 8'(k * 4), gpr[k]);
		end
		for (int k = 0; k < 16; k++)
			rchk(8'(k * 4), gpr[k]);
		apb(1'b1, OFF_STATUS, 32'hFFFFFFFF);
		rchk(OFF_STATUS, 32'h000003F3);
		apb(1'b0, 8'h5C, 32'h0);
		chk({31'h0, er}, 32'h1);
		chk(rd, 32'h0);
		apb(1'b0, 8'h01, 32'h0);
		chk({31'h0, er}, 32'h1);
		chk(rd, 32'h0);
		$display("test registers done");
		ex(16'h1080);
		rchk(OFF_GPR_BASE, 32'hFFFFFF80);
		ex(16'h41F0);
		rchk(OFF_GPR_BASE, 32'h00000080);
		ex(16'h3080);
		rchk(OFF_STATUS, 32'h000003F2);
		ex(16'h20FF);
		ex(16'h307F);
		rchk(OFF_STATUS, 32'h000003F3);
		$display("test immediates done");
		apb(1'b1, OFF_MEM_DATA, 32'h80FF7F01);
		ex(16'h1101);
		ex(16'h6210);
		rchk(8'h08, 32'hFFFFFFFF);
		ex(16'h6311);
		rchk(OFF_CORE_ST, 32'h4);
		rchk(8'h0C, gpr[3]);
		apb(1'b1, OFF_CORE_ST, 32'h4);
		ex(16'h1102);
		ex(16'h6311);
		rchk(8'h0C, 32'h00007F01);
		rchk(OFF_CORE_ST, 32'h0);
		apb(1'b1, OFF_GBASE, 32'h1);
		ex(16'h6608);
		rchk(8'h18, 32'hFFFFFF80);
		t = (pc_e & 32'hFFFFFFFC) + 32'hC;
		ex(16'h7402);
		rchk(8'h10, 32'h80FF7F01);
		rchk(OFF_EFF_ADDR, t);
		ex(16'hE3FF);
		rchk(OFF_MEM_OUT, 32'h7F);
		rchk(OFF_EFF_ADDR, 32'h80);
		$display("test loads done");
		ex(16'h1103);
		ex(16'h12FE);
		ex(16'h8124);
		rchk(OFF_MULTIPLY_ACC_LOW, 32'hFFFFFFFA);
		rchk(OFF_MULTIPLY_ACC_HIGH, 32'hFFFFFFFF);
		ex(16'h8120);
		rchk(OFF_MULTIPLY_ACC_LOW, 32'h0002FFFA);
		ex(16'h8122);
		rchk(OFF_MULTIPLY_ACC_LOW, 32'h0002FFF4);
		rchk(OFF_MULTIPLY_ACC_HIGH, 32'hFFFFFFFF);
		$display("test multiply done");
		rchk(OFF_PCNT, pc_e);
		t = pc_e + 32'hC;
		ex(16'h9004);
		ex(16'h1507);
		pc_e = t;
		rchk(OFF_PCNT, pc_e);
		rchk(8'h14, 32'h7);
		t = pc_e + 32'h8;
		ex(16'hA102);
		pc_e = t;
		rchk(OFF_PCNT, pc_e);
		apb(1'b1, OFF_VBASE, 32'h1000);
		apb(1'b1, 8'h3C, 32'h100);
		t = pc_e + 32'h2;
		ex(16'hC003);
		rchk(OFF_PCNT, 32'h100C);
		rchk(8'h3C, 32'hF8);
		ex(16'h3000);
		ex(16'hD000);
		pc_e = t;
		rchk(OFF_PCNT, pc_e);
		rchk(OFF_STATUS, 32'h000003F3);
		rchk(8'h3C, 32'h100);
		ex(16'h1540);
		t = pc_e + 32'h4;
		ex(16'hB500);
		ex(16'h9000);
		pc_e = 32'h40;
		rchk(OFF_PCNT, pc_e);
		rchk(OFF_RETADDR, t);
		rchk(OFF_CORE_ST, 32'h8);
		t = pc_e + 32'h8;
		ex(16'hA302);
		ex(16'h0000);
		pc_e = t;
		rchk(OFF_PCNT, pc_e);
		$display("test branches done");
		end_of_test();
	end
endmodule : cpu_register_set_tb
